// ---- bsf_framer.sv ----
// Purpose: Character-synchronous transmitter with underrun filler/CRC and a hunting receiver.
// Assumes: Serial clocks are slow x1 clocks sampled by aclk; data changes on the
//          falling transmit clock edge and is taken on the rising receive clock edge.
// Notes:   Register map and bit fields live in bsf_pkg.
`default_nettype none
module bsf_framer #(
    parameter logic [7:0] VEC_BASE = 8'h00 // Arbitrary base vector
) (
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        tx_clk,        // Transmit serial clock
    output logic             tx_data,       // Serial transmit data, idle high
    input  wire logic        rx_clk,        // Receive serial clock
    input  wire logic        rx_data,       // Serial receive data
    input  wire logic        cts_n,         // Clear to send, active low
    output logic             irq            // Interrupt request, active high
);
    typedef struct packed {
        logic        awh;
        logic [7:0]  awa;
        logic        wh;
        logic [31:0] wd;
        logic        ws;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  txc;
        logic [7:0]  syn1;
        logic [7:0]  syn2;
        logic [7:0]  intc;
        logic        rx_en;
        logic        tclk_s1;
        logic        tclk_s2;
        logic        tclk_d;
        logic        rclk_s1;
        logic        rclk_s2;
        logic        rclk_d;
        logic        rxd_s1;
        logic        rxd_s2;
        logic        cts_s1;
        logic        cts_s2;
        logic        cts_d;
        logic [7:0]  buffer;
        logic        buf_full;
        logic [15:0] sh;
        logic [4:0]  cnt;
        bsf_pkg::bsf_tx_t st;
        logic        incl;
        logic [15:0] crc;
        logic        syn_sel;
        logic        und;
        logic        sync_seen;
        logic        started;
        logic        ext_ip;
        logic        tx_ip;
        logic        txd;
        logic        hunt;
        logic [15:0] rsh;
        logic [2:0]  rcnt;
        logic [7:0]  rbuf;
        logic        rav;
        logic        irq;
    } bsf_state_t;

    bsf_state_t s;
    bsf_state_t next_s;

    // Bits per character; five-or-less width comes from the marker in the high bits
    function automatic logic [4:0] bsf_len(input logic [1:0] code, input logic [7:0] d);
        logic [4:0] r;
        r = 5'h08;
        case (code)
            bsf_pkg::LEN_7: r = 5'h07;
            bsf_pkg::LEN_6: r = 5'h06;
            bsf_pkg::LEN_8: r = 5'h08;
            default: begin
                if (d[7:1] == 7'h78)
                    r = 5'h01;
                else if (d[7:2] == 6'h38)
                    r = 5'h02;
                else if (d[7:3] == 5'h18)
                    r = 5'h03;
                else if (d[7:4] == 4'h8)
                    r = 5'h04;
                else
                    r = 5'h05;
            end
        endcase
        return r;
    endfunction

    function automatic logic [15:0] bsf_rev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    function automatic logic bsf_mapped(input logic [7:0] a);
        return a == bsf_pkg::A_CMD  || a == bsf_pkg::A_TXC  || a == bsf_pkg::A_SYN1 ||
               a == bsf_pkg::A_SYN2 || a == bsf_pkg::A_TXD  || a == bsf_pkg::A_STAT ||
               a == bsf_pkg::A_RXD  || a == bsf_pkg::A_INTC || a == bsf_pkg::A_RXC  ||
               a == bsf_pkg::A_VEC;
    endfunction

    logic        tick;
    logic        rtick;
    logic        bit_out;
    logic        do_wr;
    logic        rd_go;
    logic        tx_empty;
    logic [7:0]  stat;
    logic [2:0]  vcode;
    logic [15:0] cur;
    logic [15:0] pair;
    logic [15:0] rnew;
    logic        match;

    always_comb begin
        next_s   = s;
        tick     = s.tclk_d & ~s.tclk_s2;
        rtick    = ~s.rclk_d & s.rclk_s2;
        bit_out  = 1'b1;
        cur      = s.sh;
        pair     = {s.syn2, s.syn1};
        rnew     = {s.rxd_s2, s.rsh[15:1]};
        match    = 1'b0;
        tx_empty = ~s.buf_full & (s.st != bsf_pkg::TX_CRC);
        stat     = '0;
        stat[bsf_pkg::ST_RXAV]  = s.rav;
        stat[bsf_pkg::ST_TXE]   = tx_empty;
        stat[bsf_pkg::ST_HUNT]  = s.hunt;
        stat[bsf_pkg::ST_CTS]   = ~s.cts_s2;
        stat[bsf_pkg::ST_UND]   = s.und;
        stat[bsf_pkg::ST_EXTIP] = s.ext_ip;
        vcode = s.ext_ip ? bsf_pkg::VC_EXT : (s.tx_ip ? bsf_pkg::VC_TX : bsf_pkg::VC_NONE);

        // Input synchronisers
        next_s.tclk_s1 = tx_clk;
        next_s.tclk_s2 = s.tclk_s1;
        next_s.tclk_d  = s.tclk_s2;
        next_s.rclk_s1 = rx_clk;
        next_s.rclk_s2 = s.rclk_s1;
        next_s.rclk_d  = s.rclk_s2;
        next_s.rxd_s1  = rx_data;
        next_s.rxd_s2  = s.rxd_s1;
        next_s.cts_s1  = cts_n;
        next_s.cts_s2  = s.cts_s1;
        next_s.cts_d   = s.cts_s2;

        // Bus handshakes
        if (s_axi_awvalid && !s.awh && !s.bvalid) begin
            next_s.awh = 1'b1;
            next_s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.wh && !s.bvalid) begin
            next_s.wh = 1'b1;
            next_s.wd = s_axi_wdata;
            next_s.ws = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        do_wr = s.awh && s.wh && !s.bvalid;
        if (do_wr) begin
            next_s.awh    = 1'b0;
            next_s.wh     = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = bsf_mapped(s.awa) ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLV;
        end
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        rd_go = s_axi_arvalid && !s.rvalid;
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = bsf_mapped(s_axi_araddr) ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLV;
            case (s_axi_araddr)
                bsf_pkg::A_TXC:  next_s.rdata = {24'h000000, s.txc};
                bsf_pkg::A_SYN1: next_s.rdata = {24'h000000, s.syn1};
                bsf_pkg::A_SYN2: next_s.rdata = {24'h000000, s.syn2};
                bsf_pkg::A_STAT: next_s.rdata = {24'h000000, stat};
                bsf_pkg::A_RXD:  next_s.rdata = {24'h000000, s.rbuf};
                bsf_pkg::A_INTC: next_s.rdata = {24'h000000, s.intc};
                bsf_pkg::A_RXC:  next_s.rdata = {31'h00000000, s.rx_en};
                bsf_pkg::A_VEC: begin
                    if (s.intc[bsf_pkg::INT_SAV])
                        next_s.rdata = {24'h000000, VEC_BASE[7:4], vcode, VEC_BASE[0]};
                    else
                        next_s.rdata = {24'h000000, VEC_BASE};
                end
                default:         next_s.rdata = '0;
            endcase
            if (s_axi_araddr == bsf_pkg::A_RXD)
                next_s.rav = 1'b0;
        end

        // Register writes and commands; clears come before the engines so a set wins
        if (do_wr && s.ws) begin
            case (s.awa)
                bsf_pkg::A_TXC:  next_s.txc   = s.wd[7:0];
                bsf_pkg::A_SYN1: next_s.syn1  = s.wd[7:0];
                bsf_pkg::A_SYN2: next_s.syn2  = s.wd[7:0];
                bsf_pkg::A_INTC: next_s.intc  = s.wd[7:0];
                bsf_pkg::A_RXC: begin
                    next_s.rx_en = s.wd[0];
                    if (!s.wd[0])
                        next_s.hunt = 1'b1;
                end
                bsf_pkg::A_CMD: begin
                    if (s.wd[bsf_pkg::C_RSTEXT])
                        next_s.ext_ip = 1'b0;
                    if (s.wd[bsf_pkg::C_RSTTXIP])
                        next_s.tx_ip = 1'b0;
                    if (s.wd[bsf_pkg::C_RSTUND])
                        next_s.und = 1'b0;
                    if (s.wd[bsf_pkg::C_RSTCRC])
                        next_s.crc = bsf_pkg::CRC_INIT;
                    if (s.wd[bsf_pkg::C_HUNT])
                        next_s.hunt = 1'b1;
                    if (s.wd[bsf_pkg::C_CHRST]) begin
                        next_s.txc      = '0;
                        next_s.intc     = '0;
                        next_s.rx_en    = 1'b0;
                        next_s.buf_full = 1'b0;
                        next_s.cnt      = '0;
                        next_s.st       = bsf_pkg::TX_MARK;
                        next_s.txd      = 1'b1;
                        next_s.crc      = bsf_pkg::CRC_INIT;
                        next_s.und      = 1'b1;
                        next_s.sync_seen = 1'b0;
                        next_s.started  = 1'b0;
                        next_s.ext_ip   = 1'b0;
                        next_s.tx_ip    = 1'b0;
                        next_s.hunt     = 1'b1;
                        next_s.rav      = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Status change on CTS
        if (s.cts_s2 != s.cts_d && next_s.intc[bsf_pkg::INT_EXT])
            next_s.ext_ip = 1'b1;

        // Transmit engine: one bit per falling transmit clock edge
        if (tick) begin
            if (next_s.cnt == 5'h00) begin
                if (!next_s.txc[bsf_pkg::TXC_TXEN]) begin
                    next_s.st = bsf_pkg::TX_MARK;
                end else if (next_s.buf_full) begin
                    next_s.sh       = {8'h00, next_s.buffer};
                    next_s.cnt      = bsf_len(next_s.txc[bsf_pkg::TXC_LEN +: 2],
                                              next_s.buffer);
                    next_s.incl     = next_s.txc[bsf_pkg::TXC_CRC];
                    next_s.st       = bsf_pkg::TX_DATA;
                    next_s.buf_full = 1'b0;
                    next_s.started  = 1'b1;
                    next_s.sync_seen = 1'b0;
                    next_s.syn_sel  = 1'b0;
                    if (next_s.intc[bsf_pkg::INT_TX])
                        next_s.tx_ip = 1'b1;
                end else if (!next_s.und && next_s.started) begin
                    next_s.sh      = bsf_rev(next_s.crc);
                    next_s.cnt     = bsf_pkg::CRC_BITS;
                    next_s.st      = bsf_pkg::TX_CRC;
                    next_s.und     = 1'b1;
                    next_s.started = 1'b0;
                    if (next_s.intc[bsf_pkg::INT_EXT])
                        next_s.ext_ip = 1'b1;
                end else begin
                    next_s.sh  = {8'h00, next_s.syn_sel ? next_s.syn2 : next_s.syn1};
                    next_s.cnt = bsf_pkg::SYNC_BITS;
                    next_s.syn_sel = next_s.txc[bsf_pkg::TXC_SYN16] & ~next_s.syn_sel;
                    if (s.st == bsf_pkg::TX_CRC) begin
                        next_s.sync_seen = 1'b1;
                        if (next_s.intc[bsf_pkg::INT_TX])
                            next_s.tx_ip = 1'b1;
                    end else if (!next_s.sync_seen) begin
                        next_s.sync_seen = 1'b1;
                        if (next_s.intc[bsf_pkg::INT_EXT])
                            next_s.ext_ip = 1'b1;
                    end
                    next_s.st = bsf_pkg::TX_SYNC;
                end
            end
            cur = next_s.sh;
            // Disable during CRC: the rest of the 16 bits come from the sync pair
            if (next_s.st == bsf_pkg::TX_CRC && !next_s.txc[bsf_pkg::TXC_TXEN])
                cur = pair >> (bsf_pkg::CRC_BITS - next_s.cnt);
            if (next_s.cnt != 5'h00) begin
                bit_out     = cur[0];
                next_s.sh   = cur >> 1;
                next_s.cnt  = next_s.cnt - 5'h01;
                next_s.txd  = bit_out;
                if (next_s.st == bsf_pkg::TX_DATA && next_s.incl) begin
                    next_s.crc = {next_s.crc[14:0], 1'b0} ^
                                 ((bit_out ^ next_s.crc[15]) ? bsf_pkg::CRC_POLY : 16'h0000);
                end
            end else begin
                next_s.txd = 1'b1;
            end
        end

        // Data write after the engine, so a write in the load cycle is kept
        if (do_wr && s.ws && s.awa == bsf_pkg::A_TXD) begin
            next_s.buffer   = s.wd[7:0];
            next_s.buf_full = 1'b1;
            next_s.tx_ip    = 1'b0;
        end

        if (next_s.txc[bsf_pkg::TXC_BRK]) begin
            next_s.buf_full = 1'b0;
            next_s.cnt      = '0;
            next_s.st       = bsf_pkg::TX_MARK;
            next_s.txd      = 1'b0;
        end else if (next_s.st == bsf_pkg::TX_MARK) begin
            next_s.txd = 1'b1;
        end

        // Receiver: hunt for the sync pattern, then assemble characters
        if (rtick && s.rx_en) begin
            next_s.rsh = rnew;
            match = next_s.txc[bsf_pkg::TXC_SYN16] ? (rnew == pair) : (rnew[15:8] == s.syn1);
            if (next_s.hunt) begin
                if (match) begin
                    next_s.hunt = 1'b0;
                    next_s.rcnt = '0;
                end
            end else begin
                next_s.rcnt = s.rcnt + 3'h1;
                if (s.rcnt == 3'h7) begin
                    next_s.rbuf = rnew[15:8];
                    next_s.rav  = 1'b1;
                end
            end
        end

        next_s.irq = next_s.intc[bsf_pkg::INT_MASTER] & (next_s.ext_ip | next_s.tx_ip);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s      <= '0;
            s.und  <= 1'b1;
            s.txd  <= 1'b1;
            s.hunt <= 1'b1;
            s.st   <= bsf_pkg::TX_MARK;
            s.crc  <= bsf_pkg::CRC_INIT;
            // CTS idles inactive high: no false change or status bit after reset
            s.cts_s1 <= 1'b1;
            s.cts_s2 <= 1'b1;
            s.cts_d  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = ~s.awh & ~s.bvalid;
    assign s_axi_wready  = ~s.wh & ~s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign tx_data       = s.txd;
    assign irq           = s.irq;
endmodule
`default_nettype wire

// ---- bsf_pkg.sv ----
// Purpose: Shared constants and types for the character-synchronous framer.
// Assumes: AXI4-Lite slave with 32-bit data; one aligned word per register.
// Notes:   Offsets are byte addresses on the register bus.
`default_nettype none
package bsf_pkg;
    localparam logic [7:0]  A_CMD      = 8'h00;
    localparam logic [7:0]  A_TXC      = 8'h04;
    localparam logic [7:0]  A_SYN1     = 8'h08;
    localparam logic [7:0]  A_SYN2     = 8'h0c;
    localparam logic [7:0]  A_TXD      = 8'h10;
    localparam logic [7:0]  A_STAT     = 8'h14;
    localparam logic [7:0]  A_RXD      = 8'h18;
    localparam logic [7:0]  A_INTC     = 8'h1c;
    localparam logic [7:0]  A_RXC      = 8'h20;
    localparam logic [7:0]  A_VEC      = 8'h24;
    // Command bits (write one to act)
    localparam int          C_CHRST    = 0;
    localparam int          C_RSTEXT   = 1;
    localparam int          C_RSTTXIP  = 2;
    localparam int          C_RSTUND   = 3;
    localparam int          C_RSTCRC   = 4;
    localparam int          C_HUNT     = 5;
    // Transmit control bits
    localparam int          TXC_CRC    = 0;
    localparam int          TXC_TXEN   = 3;
    localparam int          TXC_BRK    = 4;
    localparam int          TXC_LEN    = 5;
    localparam int          TXC_SYN16  = 7;
    // Interrupt control bits
    localparam int          INT_EXT    = 0;
    localparam int          INT_TX     = 1;
    localparam int          INT_SAV    = 2;
    localparam int          INT_MASTER = 3;
    // Status bits
    localparam int          ST_RXAV    = 0;
    localparam int          ST_TXE     = 2;
    localparam int          ST_HUNT    = 4;
    localparam int          ST_CTS     = 5;
    localparam int          ST_UND     = 6;
    localparam int          ST_EXTIP   = 7;
    // Character length codes
    localparam logic [1:0]  LEN_5      = 2'h0;
    localparam logic [1:0]  LEN_7      = 2'h1;
    localparam logic [1:0]  LEN_6      = 2'h2;
    localparam logic [1:0]  LEN_8      = 2'h3;
    localparam logic [4:0]  SYNC_BITS  = 5'h08;
    localparam logic [4:0]  CRC_BITS   = 5'h10;
    localparam logic [15:0] CRC_POLY   = 16'h8005;
    localparam logic [15:0] CRC_INIT   = 16'h0000;
    localparam logic [2:0]  VC_NONE    = 3'h0;
    localparam logic [2:0]  VC_TX      = 3'h4;
    localparam logic [2:0]  VC_EXT     = 3'h5;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {TX_MARK, TX_DATA, TX_SYNC, TX_CRC} bsf_tx_t;
endpackage
`default_nettype wire

// ---- bsf_framer_properties.sv ----
// Purpose: Port checks for the framer.
// Assumes: Checks pause while reset is low.
// Notes:   Bound to every framer instance.
`default_nettype none
module bsf_props (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset
    input wire logic [7:0]  s_axi_awaddr,  // AW addr
    input wire logic        s_axi_awvalid, // AW valid
    input wire logic        s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata,   // W data
    input wire logic [3:0]  s_axi_wstrb,   // W strobe
    input wire logic        s_axi_wvalid,  // W valid
    input wire logic        s_axi_wready,  // W ready
    input wire logic [1:0]  s_axi_bresp,   // B resp
    input wire logic        s_axi_bvalid,  // B valid
    input wire logic        s_axi_bready,  // B ready
    input wire logic        s_axi_arvalid, // AR valid
    input wire logic        s_axi_arready, // AR ready
    input wire logic        s_axi_rvalid,  // R valid
    input wire logic        s_axi_rready,  // R ready
    input wire logic        tx_data,       // Line
    input wire logic        irq            // Interrupt
);
    logic wt;
    assign wt = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> tx_data && !irq
        && !s_axi_bvalid && s_axi_awready && s_axi_arready) else $error("bad reset state");
    AST_WR_RESP: assert property (wt |-> ##2 s_axi_bvalid) else $error("write not answered");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    AST_WR_SLVERR: assert property (wt && s_axi_awaddr > 8'h24
        |-> ##2 s_axi_bresp == bsf_pkg::RESP_SLV) else $error("unmapped write not refused");
    AST_BRK: assert property (wt && s_axi_awaddr == bsf_pkg::A_TXC
        && s_axi_wdata[bsf_pkg::TXC_BRK] |-> ##[1:3] !tx_data [*8]) else $error("no break");
    AST_IRQ_OFF: assert property (wt && s_axi_awaddr == bsf_pkg::A_INTC
        && !s_axi_wdata[bsf_pkg::INT_MASTER] |-> ##[1:3] !irq [*2]) else $error("irq not off");
endmodule
bind bsf_framer bsf_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .tx_data, .irq);
`default_nettype wire

// ---- bsf_peer.sv ----
// Purpose: Remote synchronous station on the serial line.
// Assumes: One free x1 clock serves both directions.
// Notes:   Line bits collect LSB first, newest at the top.
`default_nettype none
module bsf_peer #(
    parameter logic [31:0] RX_PAT = 32'h5a161616 // Three syncs, then one character
) (
    output logic        sclk, // Serial clock
    input  wire logic   txd,  // From framer
    output logic        rxd,  // To framer
    output logic [31:0] seen  // Recent line bits
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pat = RX_PAT;
    initial begin
        sclk = 1'h0;
        rxd = 1'h1;
        seen = 32'h0;
        #37;
        forever #80 sclk = ~sclk;
    end
    always @(posedge sclk) seen <= {txd, seen[31:1]};
    always @(negedge sclk) begin
        rxd <= pat[0];
        pat <= {pat[0], pat[31:1]};
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the framer.
// Assumes: Writes offer address and data together.
// Notes:   Line checks use the peer's bit window.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SYN = 8'h16;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0;
    logic [31:0] d;
    logic [1:0]  r;
    int          num_errors = 0;
    int          checks = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         tx_data, irq, sclk, rxd;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, seen;
    always #10 aclk = ~aclk;
    bsf_framer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1), .tx_clk(sclk),
        .tx_data, .rx_clk(sclk), .rx_data(rxd), .cts_n(1'h1), .irq);
    bsf_peer peer (.sclk, .txd(tx_data), .rxd, .seen);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hr, hb;
        hb = 1'h0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        for (int n = 0; n < 20 && !hb; n++) begin
            @(negedge aclk);
            ha = s_axi_awvalid & s_axi_awready;
            hw = s_axi_wvalid & s_axi_wready;
            hr = s_axi_arvalid & s_axi_arready;
            hb = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hr) s_axi_arvalid <= 1'h0;
        end
        chk({31'h0, hb}, 32'h1);
    endtask
    task automatic line(input logic [31:0] exp);
        for (int n = 0; n < 4000 && seen !== exp; n++) @(posedge aclk);
        chk(seen, exp);
    endtask
    // Window after data then CRC then tail: {tail, CRC sent top bit first, data}
    function automatic logic [31:0] crc_win(input logic [7:0] c, input logic [7:0] t);
        logic [15:0] crc;
        logic [15:0] rv;
        crc = 16'h0;
        for (int i = 0; i < 8; i++) begin
            crc = {crc[14:0], 1'h0} ^ ((c[i] ^ crc[15]) ? bsf_pkg::CRC_POLY : 16'h0);
        end
        for (int i = 0; i < 16; i++) rv[i] = crc[15 - i];
        return {t, rv, c};
    endfunction
    task automatic t_reset();
        bus(1'h0, bsf_pkg::A_STAT, 32'h0);
        chk(d, 32'h54);
        bus(1'h0, 8'h40, 32'h0);
        chk({d[29:0], r}, {30'h0, bsf_pkg::RESP_SLV});
        bus(1'h1, 8'h40, 32'hff);
        chk({30'h0, r}, {30'h0, bsf_pkg::RESP_SLV});
    endtask
    task automatic t_sync_irq();
        bus(1'h1, bsf_pkg::A_SYN1, {24'h0, SYN});
        bus(1'h1, bsf_pkg::A_INTC, 32'h9);
        bus(1'h1, bsf_pkg::A_TXC, 32'h68);
        line({SYN, SYN, SYN, SYN});
        chk({31'h0, irq}, 32'h1);
        bus(1'h0, bsf_pkg::A_STAT, 32'h0);
        chk({29'h0, d[7], d[6], d[2]}, 32'h7);
        bus(1'h1, bsf_pkg::A_CMD, 32'h2);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'h1, bsf_pkg::A_INTC, 32'h1);
        bus(1'h1, bsf_pkg::A_SYN2, 32'h10);
        bus(1'h1, bsf_pkg::A_TXC, 32'he8);
        line({8'h10, SYN, 8'h10, SYN});
    endtask
    task automatic t_crc(input logic [7:0] tail);
        bus(1'h1, bsf_pkg::A_TXC, 32'h69);
        bus(1'h1, bsf_pkg::A_CMD, 32'h10);
        bus(1'h1, bsf_pkg::A_TXD, 32'h3c);
        bus(1'h1, bsf_pkg::A_CMD, 32'h08);
        if (tail != SYN) begin
            d = 32'h0;
            for (int n = 0; n < 400 && !d[6]; n++) bus(1'h0, bsf_pkg::A_STAT, 32'h0);
            chk({30'h0, d[6], d[2]}, 32'h2);
            bus(1'h1, bsf_pkg::A_TXD, {24'h0, tail});
        end
        line(crc_win(8'h3c, tail));
        bus(1'h0, bsf_pkg::A_STAT, 32'h0);
        chk({29'h0, d[7], d[6], irq}, 32'h6);
    endtask
    task automatic t_break();
        bus(1'h1, bsf_pkg::A_TXC, 32'h78);
        repeat (16) @(posedge aclk);
        chk({31'h0, tx_data}, 32'h0);
        bus(1'h1, bsf_pkg::A_TXC, 32'h60);
        line(32'hffffffff);
    endtask
    task automatic t_rx();
        bus(1'h1, bsf_pkg::A_RXC, 32'h1);
        for (int n = 0; n < 400 && d !== 32'h5a; n++) bus(1'h0, bsf_pkg::A_RXD, 32'h0);
        chk(d, 32'h5a);
        bus(1'h0, bsf_pkg::A_STAT, 32'h0);
        chk({31'h0, d[4]}, 32'h0);
    endtask
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_sync_irq();
        t_crc(SYN);
        t_crc(8'hff);
        t_break();
        t_rx();
        end_sim();
    end
endmodule
`default_nettype wire
